// >>> hdl/power_on_operation_mode_select.sv
// operation mode selection at power-on, restoration and reset, with apb settings
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
// Operation
// - startup 0, sel 0: External, all switching
// - sel 1: PU mode, fixed
// - startup 0, sel 2: External/Network only, no PU
// - sel 3 or 4: combined mode, no switching
// - startup 0, sel 6: switch even while running
// - startup 0/1/2, sel 7, stop input on: as sel 0
// - sel 7, stop input off: External forced
// - startup 1/2: Network start, same switching
// - startup 10/12: Network start, panel PU/Network
// - startup 10/12, sel 0: PU/Network only
// - startup 10/12, sel 2: Network fixed
// - startup 10/12, sel 6: PU/Network while running
// - startup 2/12: keep mode over power dip
// - coasting not 9999: resume run after dip
// - startup 1/10: held start dropped after dip
// - key switches PU/External, or PU/Network where External is barred; toggle inputs switch PU/Network, PU/External
// - mode settings written only while stopped
// - startup setting needs group 0 or option
// - priority: sel, stop, ext, toggles, startup
module power_on_operation_mode_select (
    input wire logic pclk, // 200 MHz clock
    input wire logic presetn, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [opmode_pkg::APB_AW-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic output_stop_input, // output-stop pin
    input wire logic external_select_input, // external select pin
    input wire logic pu_network_toggle_input, // pu/network toggle pin
    input wire logic pu_external_toggle_input, // pu/external toggle pin
    input wire logic panel_mode_key, // panel mode key
    input wire logic motor_running, // motor running status
    input wire logic comm_option_connected, // communication option present
    input wire logic power_restored, // high once supply is back after a dip
    input wire logic start_command_in, // raw start command
    output opmode_pkg::mode_t op_mode, // current operation mode
    output logic start_command, // start command after dip filtering
    output logic resume_run // one-cycle pulse: resume previous state
);
    import opmode_pkg::*;

    policy_if pol ();
    mode_policy u_policy (
        .pol(pol)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: a change counts once stages two and three agree
    logic [PIN_COUNT-1:0] meta_q;
    logic [PIN_COUNT-1:0] sync2_q;
    logic [PIN_COUNT-1:0] sync3_q;
    logic [PIN_COUNT-1:0] pin_q;
    wire [PIN_COUNT-1:0] pin_raw = {start_command_in, power_restored, comm_option_connected,
        motor_running, panel_mode_key, pu_external_toggle_input, pu_network_toggle_input,
        external_select_input, output_stop_input};
    wire [PIN_COUNT-1:0] agree = ~(sync2_q ^ sync3_q);
    wire [PIN_COUNT-1:0] pin_d = (agree & sync3_q) | (~agree & pin_q);
    wire [PIN_COUNT-1:0] pin_chg = pin_d ^ pin_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            pin_q <= '0;
        end else begin
            meta_q <= pin_raw;
            sync2_q <= meta_q;
            sync3_q <= sync2_q;
            pin_q <= pin_d;
        end
    end

    // levels seen by the mode logic
    wire stop_on = pin_q[PIN_STOP];
    wire running = pin_q[PIN_RUN];
    wire comm_on = pin_q[PIN_COMM];
    wire start_lvl = pin_q[PIN_START];

    // key and restore act on the rising edge only
    wire key_evt = pin_chg[PIN_KEY] & pin_d[PIN_KEY];
    wire restore_evt = pin_chg[PIN_RESTORE] & pin_d[PIN_RESTORE];

    ////////////////////////////////////////////////////////////////////////////////
    // apb decode; zero wait states, data captured in the setup cycle
    logic [2:0] opsel_q;
    logic [3:0] startup_q;
    logic [15:0] coast_q;
    logic ugrp_q;
    logic sw_ref_q;
    logic wr_ref_q;
    logic block_q;
    logic init_done_q;
    logic slverr_q;
    mode_t mode_q;
    logic [31:0] prdata_q;
    logic [31:0] status_word;

    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire wr = access & pwrite;

    wire hit_cfg = paddr == OFF_MODE_CFG;
    wire hit_restart = paddr == OFF_RESTART_CFG;
    wire hit_cmd = paddr == OFF_SWITCH_CMD;
    wire hit_status = paddr == OFF_MODE_STATUS;
    wire mapped = hit_cfg | hit_restart | hit_cmd | hit_status;

    // an unmapped access is answered with an error and ignored
    wire cfg_wr = wr & hit_cfg & ~slverr_q;
    wire restart_wr = wr & hit_restart;
    wire cmd_wr = wr & hit_cmd;

    always_comb begin
        status_word = '0;
        status_word[ST_MODE_LSB +: 2] = mode_q;
        status_word[ST_SWREF_BIT] = sw_ref_q;
        status_word[ST_WRREF_BIT] = wr_ref_q;
        status_word[ST_BLOCK_BIT] = block_q;
        status_word[ST_RUN_BIT] = running;
        status_word[ST_STOP_BIT] = stop_on;
    end

    // read images; unused bits read as zero
    wire [31:0] cfg_word = {24'h000000, startup_q, 1'b0, opsel_q};
    wire [31:0] restart_word = {15'h0000, ugrp_q, coast_q};
    wire [31:0] rd_data = hit_cfg ? cfg_word : hit_restart ? restart_word :
        hit_status ? status_word : 32'h00000000;

    // zero wait states: every access cycle completes
    assign pready = access;
    assign pslverr = access & slverr_q;
    assign prdata = prdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
            slverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= pwrite ? 32'h00000000 : rd_data;
            slverr_q <= ~mapped;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // settings; a refused write leaves every field unchanged
    // fields of a mode_cfg write
    wire [2:0] wr_opsel = pwdata[OPSEL_LSB +: OPSEL_W];
    wire [3:0] wr_startup = pwdata[STARTUP_LSB +: STARTUP_W];
    wire opsel_legal = wr_opsel != OPSEL_ILLEGAL;
    wire startup_legal = (wr_startup == SU_DIRECT) || (wr_startup == SU_NET) ||
        (wr_startup == SU_NET_KEEP) || (wr_startup == SU_NET_PANEL) ||
        (wr_startup == SU_NET_PANEL_KEEP);

    // an unchanged startup value passes even while locked
    wire startup_open = ~ugrp_q | comm_on;
    wire cfg_ok = ~running & opsel_legal & startup_legal &
        (startup_open | (wr_startup == startup_q));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opsel_q <= OPSEL_RST;
            startup_q <= STARTUP_RST;
        end else if (cfg_wr && cfg_ok) begin
            opsel_q <= wr_opsel;
            startup_q <= wr_startup;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coast_q <= COAST_RST;
            ugrp_q <= UGRP_RST;
        end else if (restart_wr) begin
            coast_q <= pwdata[COAST_LSB +: COAST_W];
            ugrp_q <= pwdata[UGRP_BIT];
        end
    end

    // settings and the output-stop level feed the policy table
    assign pol.opsel = opsel_q;
    assign pol.startup = startup_q;
    assign pol.stop_on = stop_on;

    ////////////////////////////////////////////////////////////////////////////////
    // switch requests, highest priority first; the selection setting and the
    // output-stop input act through the allowed-mode mask
    wire ext_sel_on = pin_q[PIN_EXT_SEL];
    wire pu_net_chg = pin_chg[PIN_PU_NET];
    wire pu_ext_chg = pin_chg[PIN_PU_EXT];
    wire sw_req = cmd_wr & (|pwdata[CMD_NET_BIT:CMD_EXT_BIT]);
    wire soft_rst = cmd_wr & pwdata[CMD_RESET_BIT];

    mode_t key_target;
    mode_t sw_target;
    mode_t req_target;
    mode_t mode_d;

    assign key_target = (mode_q != MODE_PU) ? MODE_PU :
        (pol.allow[MODE_EXT] ? MODE_EXT : MODE_NET);
    assign sw_target = pwdata[CMD_EXT_BIT] ? MODE_EXT :
        (pwdata[CMD_PU_BIT] ? MODE_PU : MODE_NET);

    // the select pin is a level: it requests again every cycle
    wire req_valid = ext_sel_on | pu_net_chg | pu_ext_chg | key_evt | sw_req;
    assign req_target = ext_sel_on ? MODE_EXT :
        pu_net_chg ? (pin_d[PIN_PU_NET] ? MODE_PU : MODE_NET) :
        pu_ext_chg ? (pin_d[PIN_PU_EXT] ? MODE_EXT : MODE_PU) :
        key_evt ? key_target : sw_target;

    // a request for the current mode is neither taken nor refused
    wire req_new = req_valid & (req_target != mode_q);
    wire switch_ok = req_new & pol.allow[req_target] &
        (~running | pol.run_switch_ok);
    wire refuse_evt = req_new & ~switch_ok;

    ////////////////////////////////////////////////////////////////////////////////
    // mode register
    wire resume_keep = (startup_q == SU_NET_KEEP) || (startup_q == SU_NET_PANEL_KEEP);
    wire drop_start = (startup_q == SU_NET) || (startup_q == SU_NET_PANEL);

    // power-on, inverter reset, or a dip without the keep setting
    wire load_init = ~init_done_q | soft_rst | (restore_evt & ~resume_keep);

    // a mode made illegal by a settings change or the stop input falls back
    assign mode_d = load_init ? pol.init_mode :
        (!pol.allow[mode_q]) ? pol.init_mode :
        switch_ok ? req_target : mode_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= MODE_EXT;
            init_done_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            init_done_q <= 1'b1;
        end
    end

    assign op_mode = mode_q;

    ////////////////////////////////////////////////////////////////////////////////
    // power-dip handling and sticky flags (a set beats a clear)
    // block stays until the start input drops
    wire block_d = (restore_evt & drop_start & start_lvl) | (block_q & start_lvl);

    wire sw_ref_d = refuse_evt | (sw_ref_q & ~(cmd_wr & pwdata[CMD_CLR_SW_BIT]));
    wire wr_ref_d = (cfg_wr & ~cfg_ok) | (wr_ref_q & ~(cmd_wr & pwdata[CMD_CLR_WR_BIT]));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_q <= 1'b0;
            start_command <= 1'b0;
            resume_run <= 1'b0;
            sw_ref_q <= 1'b0;
            wr_ref_q <= 1'b0;
        end else begin
            block_q <= block_d;
            start_command <= start_lvl & ~block_d;
            resume_run <= restore_evt & (coast_q != COAST_NO_RESTART);
            sw_ref_q <= sw_ref_d;
            wr_ref_q <= wr_ref_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    // all checks on pclk, off during reset
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_power_on_ext: assert property (
        !init_done_q && opsel_q == OPSEL_FREE && startup_q == SU_DIRECT |=> mode_q == MODE_EXT)
        else $error("power-on mode not External for settings 0/0");

    a_pu_fixed_mode: assert property (
        init_done_q && opsel_q == OPSEL_PU |=> mode_q == MODE_PU)
        else $error("selection 1 did not hold PU mode");

    a_no_pu_entry: assert property (
        init_done_q && opsel_q == OPSEL_NO_PU && startup_q == SU_DIRECT
        && mode_q != MODE_PU |=> mode_q != MODE_PU)
        else $error("entered PU mode under selection 2");

    a_combined_fixed: assert property (
        init_done_q && (opsel_q == OPSEL_COMB1 || opsel_q == OPSEL_COMB2)
        |=> mode_q == MODE_COMBINED)
        else $error("combined mode left under selection 3 or 4");

    a_stop_forces_ext: assert property (
        init_done_q && opsel_q == OPSEL_STOP_SEL && !stop_on |=> mode_q == MODE_EXT)
        else $error("stop input off did not force External mode");

    a_net_fixed_panel: assert property (
        init_done_q && opsel_q == OPSEL_NO_PU && startup_q == SU_NET_PANEL_KEEP
        |=> mode_q == MODE_NET)
        else $error("network mode not held for panel startup and selection 2");

    a_keep_mode_dip: assert property (
        init_done_q && restore_evt && resume_keep && pol.allow[mode_q] && !req_valid
        |=> $stable(mode_q))
        else $error("mode lost over power dip with keep setting");

    a_resume_pulse: assert property (
        restore_evt |=> resume_run == ($past(coast_q) != COAST_NO_RESTART) ##1 !resume_run)
        else $error("resume pulse wrong after power dip");

    a_start_dropped: assert property (
        restore_evt && drop_start && start_lvl |=> !start_command [*2])
        else $error("held start command passed after power dip");

    a_cfg_while_run: assert property (
        cfg_wr && running |=> $stable(opsel_q) && $stable(startup_q) && wr_ref_q)
        else $error("mode settings changed while running");

    a_startup_lock: assert property (
        cfg_wr && ugrp_q && !comm_on && wr_startup != startup_q |=> $stable(startup_q))
        else $error("startup setting written while locked");

    a_run_switch_gate: assert property (
        init_done_q && running && opsel_q != OPSEL_RUN_SW && !load_init
        && pol.allow[mode_q] |=> $stable(mode_q))
        else $error("mode switched while running without selection 6");

    a_ext_sel_wins: assert property (
        init_done_q && !load_init && ext_sel_on && pol.allow[MODE_EXT] && pol.allow[mode_q]
        && (!running || pol.run_switch_ok) |=> mode_q == MODE_EXT)
        else $error("external select did not win");

    c_key_switch: cover property (key_evt && switch_ok ##1 mode_q == MODE_PU);

    c_dip_restore: cover property (restore_evt && resume_keep ##1 resume_run);

    c_refused: cover property (refuse_evt ##1 sw_ref_q);

    c_run_switch: cover property (running && pol.run_switch_ok && switch_ok);
endmodule

// >>> include/opmode_pkg.sv
// shared constants and types for the power-on operation mode selector
package opmode_pkg;
    typedef enum logic [1:0] {MODE_EXT, MODE_PU, MODE_NET, MODE_COMBINED} mode_t;

    ////////////////////////////////////////////////////////////////////////////////
    // apb register byte offsets
    localparam int APB_AW = 4;
    localparam logic [3:0] OFF_MODE_CFG = 4'h0;
    localparam logic [3:0] OFF_RESTART_CFG = 4'h4;
    localparam logic [3:0] OFF_SWITCH_CMD = 4'h8;
    localparam logic [3:0] OFF_MODE_STATUS = 4'hc;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int OPSEL_LSB = 0;
    localparam int OPSEL_W = 3;
    localparam int STARTUP_LSB = 4;
    localparam int STARTUP_W = 4;
    localparam int COAST_LSB = 0;
    localparam int COAST_W = 16;
    localparam int UGRP_BIT = 16;
    localparam int CMD_EXT_BIT = 0;
    localparam int CMD_PU_BIT = 1;
    localparam int CMD_NET_BIT = 2;
    localparam int CMD_RESET_BIT = 3;
    localparam int CMD_CLR_SW_BIT = 4;
    localparam int CMD_CLR_WR_BIT = 5;
    localparam int ST_MODE_LSB = 0;
    localparam int ST_SWREF_BIT = 4;
    localparam int ST_WRREF_BIT = 5;
    localparam int ST_BLOCK_BIT = 6;
    localparam int ST_RUN_BIT = 7;
    localparam int ST_STOP_BIT = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // setting codes
    localparam logic [2:0] OPSEL_FREE = 3'h0;
    localparam logic [2:0] OPSEL_PU = 3'h1;
    localparam logic [2:0] OPSEL_NO_PU = 3'h2;
    localparam logic [2:0] OPSEL_COMB1 = 3'h3;
    localparam logic [2:0] OPSEL_COMB2 = 3'h4;
    localparam logic [2:0] OPSEL_ILLEGAL = 3'h5;
    localparam logic [2:0] OPSEL_RUN_SW = 3'h6;
    localparam logic [2:0] OPSEL_STOP_SEL = 3'h7;
    localparam logic [3:0] SU_DIRECT = 4'h0;
    localparam logic [3:0] SU_NET = 4'h1;
    localparam logic [3:0] SU_NET_KEEP = 4'h2;
    localparam logic [3:0] SU_NET_PANEL = 4'ha;
    localparam logic [3:0] SU_NET_PANEL_KEEP = 4'hc;
    localparam logic [15:0] COAST_NO_RESTART = 16'h270f;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values and permission masks (bit index = mode code)
    localparam logic [2:0] OPSEL_RST = 3'h0;
    localparam logic [3:0] STARTUP_RST = 4'h0;
    localparam logic [15:0] COAST_RST = 16'h270f;
    localparam logic UGRP_RST = 1'b0;
    localparam logic [3:0] ALLOW_EXT = 4'h1;
    localparam logic [3:0] ALLOW_PU = 4'h2;
    localparam logic [3:0] ALLOW_NET = 4'h4;
    localparam logic [3:0] ALLOW_COMB = 4'h8;

    ////////////////////////////////////////////////////////////////////////////////
    // pin indices in the synchroniser vector
    localparam int PIN_STOP = 0;
    localparam int PIN_EXT_SEL = 1;
    localparam int PIN_PU_NET = 2;
    localparam int PIN_PU_EXT = 3;
    localparam int PIN_KEY = 4;
    localparam int PIN_RUN = 5;
    localparam int PIN_COMM = 6;
    localparam int PIN_RESTORE = 7;
    localparam int PIN_START = 8;
    localparam int PIN_COUNT = 9;
endpackage

// >>> include/policy_if.sv
// settings to mode-permission link between the selector and its policy table
`timescale 1ns/100ps
interface policy_if;
    import opmode_pkg::*;
    logic [2:0] opsel;
    logic [3:0] startup;
    logic stop_on;
    mode_t init_mode;
    logic [3:0] allow;
    logic run_switch_ok;
    modport ctrl (output opsel, startup, stop_on, input init_mode, allow, run_switch_ok);
    modport policy (input opsel, startup, stop_on, output init_mode, allow, run_switch_ok);
endinterface

// >>> hdl/mode_policy.sv
// startup mode and allowed-mode table from the two mode settings and the output-stop input
`timescale 1ns/100ps
module mode_policy (
    policy_if.policy pol // settings in, startup mode and permissions out
);
    import opmode_pkg::*;

    wire grp_panel = (pol.startup == SU_NET_PANEL) || (pol.startup == SU_NET_PANEL_KEEP);
    wire grp_net = (pol.startup == SU_NET) || (pol.startup == SU_NET_KEEP);
    wire sel_comb = (pol.opsel == OPSEL_COMB1) || (pol.opsel == OPSEL_COMB2);
    wire sel_stop = pol.opsel == OPSEL_STOP_SEL;
    wire stop_forced = sel_stop && !pol.stop_on;

    // panel-startup group with selection 7 behaves as startup setting 0
    assign pol.allow = (pol.opsel == OPSEL_PU) ? ALLOW_PU :
        sel_comb ? ALLOW_COMB :
        stop_forced ? ALLOW_EXT :
        (pol.opsel == OPSEL_NO_PU) ? (grp_panel ? ALLOW_NET : (ALLOW_EXT | ALLOW_NET)) :
        (grp_panel && !sel_stop) ? (ALLOW_PU | ALLOW_NET) :
        (ALLOW_EXT | ALLOW_PU | ALLOW_NET);

    assign pol.init_mode = (pol.opsel == OPSEL_PU) ? MODE_PU :
        sel_comb ? MODE_COMBINED :
        stop_forced ? MODE_EXT :
        (sel_stop && grp_panel) ? MODE_EXT :
        (grp_net || grp_panel) ? MODE_NET :
        MODE_EXT;

    assign pol.run_switch_ok = pol.opsel == OPSEL_RUN_SW;
endmodule

// >>> sim/panel_terminals.sv
// panel keys and terminal pins driven at the selector's far side
`timescale 1ns/100ps
module panel_terminals
    import opmode_pkg::*;
(
    input wire logic pclk, // controller clock
    output logic [PIN_COUNT-1:0] pin // terminal and panel levels, indexed by PIN_*
);
    initial begin
        pin = '0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pins are switch contacts: change only just after an edge, then hold
    task automatic set(input int idx, input logic v);
        @(posedge pclk);
        pin[idx] <= v;
    endtask

    // key held long enough to clear the three-flop synchroniser
    task automatic press();
        set(PIN_KEY, 1'b1);
        repeat (8) @(posedge pclk);
        set(PIN_KEY, 1'b0);
        repeat (8) @(posedge pclk);
    endtask
endmodule

// >>> sim/testbench.sv
// self-checking bench for the power-on operation mode selector
`timescale 1ns/100ps
module testbench;
    import opmode_pkg::*;
    localparam logic [3:0] SUS [5] = '{SU_DIRECT, SU_NET, SU_NET_KEEP, SU_NET_PANEL,
                                       SU_NET_PANEL_KEEP};
    // startup, selection, software request, mode expected afterwards
    localparam logic [11:0] SWT [10] = '{
        {4'h0, 3'h0, 3'h2, 2'h1}, {4'h0, 3'h2, 3'h2, 2'h0}, {4'h0, 3'h2, 3'h4, 2'h2},
        {4'h0, 3'h1, 3'h1, 2'h1}, {4'h0, 3'h3, 3'h4, 2'h3}, {4'h1, 3'h0, 3'h1, 2'h0},
        {4'ha, 3'h0, 3'h1, 2'h2}, {4'ha, 3'h0, 3'h2, 2'h1}, {4'ha, 3'h2, 3'h2, 2'h2},
        {4'hc, 3'h6, 3'h2, 2'h1}};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [3:0] paddr = 4'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [PIN_COUNT-1:0] pin;
    mode_t op_mode;
    logic start_command;
    logic resume_run;
    logic [31:0] rd;
    logic err;
    int fails = 0;
    int checks = 0;

    initial begin
        forever #2.5 pclk = ~pclk;
    end

    panel_terminals pt_u (.pclk(pclk), .pin(pin));

    power_on_operation_mode_select dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .output_stop_input(pin[PIN_STOP]), .external_select_input(pin[PIN_EXT_SEL]),
        .pu_network_toggle_input(pin[PIN_PU_NET]), .pu_external_toggle_input(pin[PIN_PU_EXT]),
        .panel_mode_key(pin[PIN_KEY]), .motor_running(pin[PIN_RUN]),
        .comm_option_connected(pin[PIN_COMM]), .power_restored(pin[PIN_RESTORE]),
        .start_command_in(pin[PIN_START]), .op_mode(op_mode), .start_command(start_command),
        .resume_run(resume_run));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chkm(input mode_t e, input string what);
        chk({30'h0, op_mode}, {30'h0, e}, what);
    endtask

    task automatic pause(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // one apb transfer; waits for pready under a bound, captures data and error
    task automatic apb(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 64) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 64) begin
            fails++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // settings, then reload the startup mode and clear both sticky flags
    task automatic cfg(input logic [3:0] su, input logic [2:0] sel);
        apb(1'b1, OFF_MODE_CFG, {24'h0, su, 1'b0, sel});
        apb(1'b1, OFF_SWITCH_CMD, 32'h38);
        pause(3);
    endtask

    task automatic sw(input logic [2:0] bits);
        apb(1'b1, OFF_SWITCH_CMD, {29'h0, bits});
        pause(3);
    endtask

    task automatic dip(output int pulses);
        pulses = 0;
        pt_u.set(PIN_RESTORE, 1'b0);
        pause(8);
        pt_u.set(PIN_RESTORE, 1'b1);
        repeat (12) begin
            @(posedge pclk);
            if (resume_run === 1'b1) pulses++;
        end
    endtask

    function automatic mode_t exp_init(logic [3:0] su, logic [2:0] sel, logic stop);
        if (sel == OPSEL_PU) return MODE_PU;
        if (sel == OPSEL_COMB1 || sel == OPSEL_COMB2) return MODE_COMBINED;
        if (sel == OPSEL_STOP_SEL && (!stop || su >= SU_NET_PANEL)) return MODE_EXT;
        if (su == SU_DIRECT) return MODE_EXT;
        return MODE_NET;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int i;
        int j;
        int k;
        int p;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        pause(2);
        chkm(MODE_EXT, "mode after reset");
        apb(1'b0, OFF_MODE_CFG, 32'h0);
        chk(rd, 32'h0, "mode_cfg reset");
        apb(1'b0, OFF_RESTART_CFG, 32'h0);
        chk(rd, 32'h270f, "restart_cfg reset");
        apb(1'b0, 4'h2, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        $display("test reset done");
        for (i = 0; i < 5; i++) for (j = 0; j < 8; j++) if (j != 5) for (k = 0; k < 2; k++) begin
            pt_u.set(PIN_STOP, k[0]);
            pause(8);
            cfg(SUS[i], j[2:0]);
            chkm(exp_init(SUS[i], j[2:0], k[0]), "startup mode");
        end
        $display("test startup table done");
        for (i = 0; i < 10; i++) begin
            cfg(SWT[i][11:8], SWT[i][7:5]);
            sw(SWT[i][4:2]);
            chkm(mode_t'(SWT[i][1:0]), "software switch");
        end
        apb(1'b0, OFF_MODE_STATUS, 32'h0);
        chk(rd & 32'h10, 32'h0, "no refusal on allowed switch");
        $display("test switch table done");
        cfg(SU_DIRECT, OPSEL_FREE);
        pt_u.set(PIN_RUN, 1'b1);
        pause(8);
        sw(3'h2);
        chkm(MODE_EXT, "switch while running");
        apb(1'b0, OFF_MODE_STATUS, 32'h0);
        chk(rd & 32'h10, 32'h10, "switch refused flag");
        pt_u.set(PIN_RUN, 1'b0);
        pause(8);
        cfg(SU_DIRECT, OPSEL_RUN_SW);
        pt_u.set(PIN_RUN, 1'b1);
        pause(8);
        sw(3'h4);
        chkm(MODE_NET, "running switch to net");
        apb(1'b1, OFF_MODE_CFG, 32'h0);
        apb(1'b0, OFF_MODE_CFG, 32'h0);
        chk(rd, 32'h6, "settings held while running");
        apb(1'b0, OFF_MODE_STATUS, 32'h0);
        chk(rd & 32'h20, 32'h20, "write refused flag");
        pt_u.set(PIN_RUN, 1'b0);
        pause(8);
        $display("test running done");
        pt_u.set(PIN_STOP, 1'b0);
        cfg(SU_DIRECT, OPSEL_STOP_SEL);
        sw(3'h4);
        chkm(MODE_EXT, "stop off holds external");
        pt_u.set(PIN_STOP, 1'b1);
        pause(8);
        sw(3'h4);
        chkm(MODE_NET, "stop on allows net");
        pt_u.set(PIN_STOP, 1'b0);
        pause(8);
        chkm(MODE_EXT, "stop off forces external");
        $display("test stop input done");
        cfg(SU_DIRECT, OPSEL_FREE);
        pt_u.set(PIN_PU_NET, 1'b1);
        pause(8);
        chkm(MODE_PU, "toggle on gives pu");
        pt_u.set(PIN_EXT_SEL, 1'b1);
        pause(8);
        pt_u.set(PIN_PU_NET, 1'b0);
        pause(8);
        chkm(MODE_EXT, "external select outranks toggle");
        pt_u.set(PIN_EXT_SEL, 1'b0);
        pause(8);
        pt_u.set(PIN_PU_EXT, 1'b1);
        pause(8);
        pt_u.set(PIN_PU_EXT, 1'b0);
        pause(8);
        chkm(MODE_PU, "external toggle off gives pu");
        cfg(SU_NET_PANEL, OPSEL_FREE);
        pt_u.press();
        chkm(MODE_PU, "key net to pu");
        pt_u.press();
        chkm(MODE_NET, "key pu to net");
        $display("test toggles done");
        apb(1'b1, OFF_RESTART_CFG, 32'h1_0005);
        apb(1'b1, OFF_MODE_CFG, 32'h10);
        apb(1'b0, OFF_MODE_CFG, 32'h0);
        chk(rd, 32'ha0, "startup locked by group");
        pt_u.set(PIN_COMM, 1'b1);
        pause(8);
        apb(1'b1, OFF_MODE_CFG, 32'h10);
        apb(1'b0, OFF_MODE_CFG, 32'h0);
        chk(rd, 32'h10, "startup write with option");
        pt_u.set(PIN_COMM, 1'b0);
        apb(1'b1, OFF_RESTART_CFG, 32'h5);
        $display("test write lock done");
        cfg(SU_NET_KEEP, OPSEL_FREE);
        sw(3'h2);
        pt_u.set(PIN_START, 1'b1);
        dip(p);
        chkm(MODE_PU, "mode kept over dip");
        chk(p, 1, "resume pulse");
        chk({31'h0, start_command}, 32'h1, "start kept");
        cfg(SU_NET, OPSEL_FREE);
        sw(3'h2);
        dip(p);
        chkm(MODE_NET, "startup reload after dip");
        chk({31'h0, start_command}, 32'h0, "held start dropped");
        apb(1'b1, OFF_RESTART_CFG, {16'h0, COAST_NO_RESTART});
        pt_u.set(PIN_START, 1'b0);
        dip(p);
        chk(p, 0, "no resume without restart");
        $display("test power dip done");
        stop_test();
    end

    initial begin
        repeat (90000) @(posedge pclk);
        fails++;
        stop_test();
    end
endmodule
